// ===== src/io_port_pkg.sv
// Package for the change-notify I/O port: register offsets, reset values and carriers.
// Assumes a 32-bit APB bus with one aligned word per register.
package io_port_pkg;

   localparam int unsigned PORT_WIDTH = 16;

   localparam logic [11:0] OFF_DIRECTION_CONTROL = 12'h000;
   localparam logic [11:0] OFF_OUTPUT_LATCH      = 12'h004;
   localparam logic [11:0] OFF_PIN_LEVEL_READ    = 12'h008;
   localparam logic [11:0] OFF_OPEN_DRAIN_SELECT = 12'h00C;
   localparam logic [11:0] OFF_ANALOG_SELECT     = 12'h010;
   localparam logic [11:0] OFF_CHANGE_ENABLE     = 12'h014;
   localparam logic [11:0] OFF_PULLUP_ENABLE     = 12'h018;
   localparam logic [11:0] OFF_PULLDOWN_ENABLE   = 12'h01C;
   localparam logic [11:0] OFF_IRQ_STATUS        = 12'h020;
   localparam logic [11:0] OFF_IRQ_MASK          = 12'h024;
   localparam logic [11:0] OFF_CHANGE_PENDING    = 12'h028;

   localparam logic [15:0] RST_DIRECTION_CONTROL = 16'hFFFF;
   localparam logic [15:0] RST_ANALOG_SELECT     = 16'hFFFF;
   localparam logic [15:0] RST_ZERO              = 16'h0000;

   localparam int unsigned IRQ_CHANGE_BIT = 0;
   localparam int unsigned IRQ_WIDTH      = 1;

   // Per-pin pad controls that travel together to the pad ring.
   typedef struct packed {
      logic [PORT_WIDTH-1:0] out_level;
      logic [PORT_WIDTH-1:0] out_enable;
      logic [PORT_WIDTH-1:0] pullup_en;
      logic [PORT_WIDTH-1:0] pulldown_en;
      logic [PORT_WIDTH-1:0] analog_en;
   } pad_ctrl_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage : io_port_pkg

// ===== src/change_latch.sv
// Asynchronous change latch for one pin, able to catch an edge with the system clock stopped.
// Assumes the reference level is held stable by the clocked domain while armed.
`timescale 1ns/1ns
module change_latch (
   // Pin and arming
   input  wire logic pin_in,
   input  wire logic ref_level_in,
   input  wire logic armed_in,
   // Clear from the clocked domain
   input  wire logic clear_in,
   // Sticky result
   output logic      changed_out
);
   logic differ;

   // No clock is needed: a mismatch against the reference sets the latch itself.
   assign differ = armed_in & (pin_in ^ ref_level_in);

   always_latch begin
      if (clear_in) begin
         changed_out = 1'b0;
      end else if (differ) begin
         changed_out = 1'b1;
      end
   end
endmodule : change_latch

// ===== src/io_port_change_notify.sv
// APB-controlled I/O port slice with analog select, pulls, open drain and change notification.
// Assumes pin inputs are synchronous to clk_sys_in; the pad ring resolves the pin wire.
//
// Contract
// - Set open-drain bit drives pin open-drain.
// - Analog select resets to all ones.
// - Analog pins read back as zero.
// - Analog output still reaches analog peripheral.
// - Selected pin change raises interrupt request.
// - Change detection works with clocks stopped.
// - Enable bit includes pin; clear excludes it.
// - Separate per-pin pull-up and pull-down enables.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
module io_port_change_notify #(
   parameter int unsigned WIDTH = io_port_pkg::PORT_WIDTH
) (
   // Clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rst_in,
   // APB slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [11:0]       paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // Pins
   input  wire logic [WIDTH-1:0]  pin_in,
   output logic      [WIDTH-1:0]  pin_out,
   output logic      [WIDTH-1:0]  pin_oe_out,
   output logic      [WIDTH-1:0]  pullup_en_out,
   output logic      [WIDTH-1:0]  pulldown_en_out,
   output logic      [WIDTH-1:0]  analog_en_out,
   output logic      [WIDTH-1:0]  analog_drive_out,
   // Interrupt
   output logic                   irq_out
);

   typedef struct packed {
      logic [WIDTH-1:0]     direction_control;
      logic [WIDTH-1:0]     output_latch;
      logic [WIDTH-1:0]     open_drain_select;
      logic [WIDTH-1:0]     analog_select;
      logic [WIDTH-1:0]     change_notice_enable;
      logic [WIDTH-1:0]     weak_pullup_enable;
      logic [WIDTH-1:0]     weak_pulldown_enable;
      logic [WIDTH-1:0]     ref_level;
      logic [WIDTH-1:0]     latch_clear;
      logic [io_port_pkg::IRQ_WIDTH-1:0] irq_status;
      logic [io_port_pkg::IRQ_WIDTH-1:0] irq_mask;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      io_port_pkg::pad_ctrl_t pad;
      logic [WIDTH-1:0]     analog_drive;
      logic                 irq;
   } state_t;

   state_t                s_q;
   state_t                s_d;
   io_port_pkg::apb_req_t req;
   logic [WIDTH-1:0]      changed;
   logic [WIDTH-1:0]      pin_level_read;

   assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                  paddr: paddr_in, pwdata: pwdata_in};

   // One latch per pin so an edge in sleep is held until the clock returns.
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      change_latch u_latch (
         .pin_in       (pin_in[i]),
         .ref_level_in (s_q.ref_level[i]),
         .armed_in     (s_q.change_notice_enable[i]),
         .clear_in     (s_q.latch_clear[i] | rst_in),
         .changed_out  (changed[i])
      );
   end

   // Analog pins read low; digital pins show their live level.
   assign pin_level_read = pin_in & ~s_q.analog_select;

   always_comb begin
      logic             wr;
      logic             rd;
      logic             hit;
      logic [31:0]      rdata;
      logic             any_change;
      logic [WIDTH-1:0] wd;
      wr         = 1'b0;
      rd         = 1'b0;
      hit        = 1'b1;
      rdata      = 32'h0000_0000;
      any_change = 1'b0;
      wd         = req.pwdata[WIDTH-1:0];
      s_d        = s_q;

      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      // Answer one cycle after the access phase begins, so every access has one wait state.
      if (req.psel && req.penable && !s_q.pready) begin
         wr = req.pwrite;
         rd = !req.pwrite;
         s_d.pready = 1'b1;
      end

      // Compare against the level seen when armed; any enabled mismatch is one event.
      s_d.latch_clear = '0;
      for (int i = 0; i < WIDTH; i++) begin
         if (changed[i]) begin
            any_change         = 1'b1;
            s_d.ref_level[i]   = pin_in[i];
            s_d.latch_clear[i] = 1'b1;
         end else if (!s_q.change_notice_enable[i]) begin
            s_d.ref_level[i]   = pin_in[i];
         end
      end

      case (req.paddr)
         io_port_pkg::OFF_DIRECTION_CONTROL: begin
            rdata[WIDTH-1:0] = s_q.direction_control;
            if (wr) begin
               s_d.direction_control = wd;
            end
         end
         io_port_pkg::OFF_OUTPUT_LATCH: begin
            rdata[WIDTH-1:0] = s_q.output_latch;
            if (wr) begin
               s_d.output_latch = wd;
            end
         end
         io_port_pkg::OFF_PIN_LEVEL_READ: begin
            rdata[WIDTH-1:0] = pin_level_read;
            if (wr) begin
               s_d.output_latch = wd;
            end
         end
         io_port_pkg::OFF_OPEN_DRAIN_SELECT: begin
            rdata[WIDTH-1:0] = s_q.open_drain_select;
            if (wr) begin
               s_d.open_drain_select = wd;
            end
         end
         io_port_pkg::OFF_ANALOG_SELECT: begin
            rdata[WIDTH-1:0] = s_q.analog_select;
            if (wr) begin
               s_d.analog_select = wd;
            end
         end
         io_port_pkg::OFF_CHANGE_ENABLE: begin
            rdata[WIDTH-1:0] = s_q.change_notice_enable;
            if (wr) begin
               s_d.change_notice_enable = wd;
            end
         end
         io_port_pkg::OFF_PULLUP_ENABLE: begin
            rdata[WIDTH-1:0] = s_q.weak_pullup_enable;
            if (wr) begin
               s_d.weak_pullup_enable = wd;
            end
         end
         io_port_pkg::OFF_PULLDOWN_ENABLE: begin
            rdata[WIDTH-1:0] = s_q.weak_pulldown_enable;
            if (wr) begin
               s_d.weak_pulldown_enable = wd;
            end
         end
         io_port_pkg::OFF_IRQ_STATUS: begin
            rdata[io_port_pkg::IRQ_WIDTH-1:0] = s_q.irq_status;
            if (wr) begin
               s_d.irq_status = s_q.irq_status & ~req.pwdata[io_port_pkg::IRQ_WIDTH-1:0];
            end
         end
         io_port_pkg::OFF_IRQ_MASK: begin
            rdata[io_port_pkg::IRQ_WIDTH-1:0] = s_q.irq_mask;
            if (wr) begin
               s_d.irq_mask = req.pwdata[io_port_pkg::IRQ_WIDTH-1:0];
            end
         end
         io_port_pkg::OFF_CHANGE_PENDING: begin
            rdata[WIDTH-1:0] = changed;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      if (s_d.pready) begin
         s_d.pslverr = !hit;
         if (rd) begin
            s_d.prdata = rdata;
         end
      end

      // A change in the same cycle as a write-one-to-clear still sets the flag.
      if (any_change) begin
         s_d.irq_status[io_port_pkg::IRQ_CHANGE_BIT] = 1'b1;
      end

      // Open drain drives only low: enable when latch is 0, else release.
      for (int i = 0; i < WIDTH; i++) begin
         if (s_d.open_drain_select[i]) begin
            s_d.pad.out_enable[i] = !s_d.direction_control[i] && !s_d.output_latch[i];
            s_d.pad.out_level[i]  = 1'b0;
         end else begin
            s_d.pad.out_enable[i] = !s_d.direction_control[i];
            s_d.pad.out_level[i]  = s_d.output_latch[i];
         end
      end
      s_d.pad.pullup_en   = s_d.weak_pullup_enable;
      s_d.pad.pulldown_en = s_d.weak_pulldown_enable;
      s_d.pad.analog_en   = s_d.analog_select;
      // An output pin in analog mode still offers its level to the converters.
      s_d.analog_drive = s_d.analog_select & ~s_d.direction_control & s_d.output_latch;
      s_d.irq = |(s_d.irq_status & s_d.irq_mask);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_q                      <= '0;
         s_q.direction_control    <= io_port_pkg::RST_DIRECTION_CONTROL[WIDTH-1:0];
         s_q.output_latch         <= io_port_pkg::RST_ZERO[WIDTH-1:0];
         s_q.analog_select        <= io_port_pkg::RST_ANALOG_SELECT[WIDTH-1:0];
         s_q.pad.analog_en        <= io_port_pkg::RST_ANALOG_SELECT[WIDTH-1:0];
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_out       = s_q.prdata;
   assign pready_out       = s_q.pready;
   assign pslverr_out      = s_q.pslverr;
   assign pin_out          = s_q.pad.out_level;
   assign pin_oe_out       = s_q.pad.out_enable;
   assign pullup_en_out    = s_q.pad.pullup_en;
   assign pulldown_en_out  = s_q.pad.pulldown_en;
   assign analog_en_out    = s_q.pad.analog_en;
   assign analog_drive_out = s_q.analog_drive;
   assign irq_out          = s_q.irq;

endmodule : io_port_change_notify

// ===== verif/pin_switches.sv
// Pin model: external switches that hold every pin the port leaves released.
// Assumes an output enable is high while the port drives the pin.
`timescale 1ns/1ns
module pin_switches (
   // Port side
   input  wire logic [15:0] drv_in,
   input  wire logic [15:0] oe_in,
   // Switch levels
   input  wire logic [15:0] sw_in,
   output logic      [15:0] level_out
);
   // The port's own driver wins, so a switch never fights an output pin.
   assign level_out = (oe_in & drv_in) | (~oe_in & sw_in);
endmodule : pin_switches

// ===== verif/io_port_change_notify_asserts.sv
// Checker for the change-notify port: APB handshake, reset state and pad outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module port_asserts #(
   parameter int unsigned WIDTH = 16
) (
   input wire logic             clk_sys_in,
   input wire logic             rst_in,
   input wire logic             psel_in,
   input wire logic             penable_in,
   input wire logic             pwrite_in,
   input wire logic [11:0]      paddr_in,
   input wire logic [31:0]      pwdata_in,
   input wire logic [31:0]      prdata_out,
   input wire logic             pready_out,
   input wire logic             pslverr_out,
   input wire logic [WIDTH-1:0] pin_oe_out,
   input wire logic [WIDTH-1:0] pullup_en_out,
   input wire logic [WIDTH-1:0] pulldown_en_out,
   input wire logic [WIDTH-1:0] analog_en_out,
   input wire logic [WIDTH-1:0] analog_drive_out,
   input wire logic             irq_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   logic acc;
   assign acc = psel_in && penable_in && !pready_out;
   a_ready_answer: assert property (acc |=> pready_out) else $error("No pready after access.");
   a_ready_pulse: assert property (pready_out |=> !pready_out) else $error("Pready held.");
   a_error_paired: assert property (pslverr_out |-> pready_out) else $error("Lone pslverr.");
   a_analog_reset: assert property ($fell(rst_in) |-> analog_en_out == '1)
      else $error("Analog select not all ones after reset.");
   a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out && pin_oe_out == '0
      && pullup_en_out == '0 && !pready_out) else $error("Outputs active after reset.");
   a_analog_reads_zero: assert property (
      acc && !pwrite_in && paddr_in == io_port_pkg::OFF_PIN_LEVEL_READ
      |=> (prdata_out[WIDTH-1:0] & analog_en_out) == '0) else $error("Analog pin read high.");
   a_pullup_write: assert property (
      acc && pwrite_in && paddr_in == io_port_pkg::OFF_PULLUP_ENABLE
      |=> pullup_en_out == pwdata_in[WIDTH-1:0] && $stable(pulldown_en_out))
      else $error("Pull-up write wrong.");
   a_drive_needs_analog: assert property ((analog_drive_out & ~analog_en_out) == '0)
      else $error("Converter drive on digital pin.");
   c_write: cover property (acc && pwrite_in);
   c_error: cover property (pslverr_out);
   c_irq: cover property ($rose(irq_out));
endmodule : port_asserts
bind io_port_change_notify port_asserts #(.WIDTH(WIDTH)) u_port_asserts (
   .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out),
   .pulldown_en_out(pulldown_en_out), .analog_en_out(analog_en_out),
   .analog_drive_out(analog_drive_out), .irq_out(irq_out));

// ===== verif/io_port_change_notify_tb.sv
// Self-checking bench for the change-notify port: registers, pads and interrupt.
// Assumes the pin model resolves every pin; the clock can be halted to mimic sleep.
`timescale 1ns/1ns
module io_port_change_notify_tb;
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        run = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rv;
   logic        ready, slverr, ev, irq;
   logic [15:0] lvl, pout, poe, pu, pd, aen, adrv;
   logic [15:0] sw = 16'hA5A5;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   io_port_change_notify u_io_port_change_notify (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata), .prdata_out(rdata),
      .pready_out(ready), .pslverr_out(slverr), .pin_in(lvl), .pin_out(pout),
      .pin_oe_out(poe), .pullup_en_out(pu), .pulldown_en_out(pd), .analog_en_out(aen),
      .analog_drive_out(adrv), .irq_out(irq));
   pin_switches u_pin_switches (.drv_in(pout), .oe_in(poe), .sw_in(sw), .level_out(lvl));
   initial forever begin
      #5;
      if (run) clk_sys_in = ~clk_sys_in;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys_in);
      pen <= 1'b1;
      n = 0;
      // Look at pready between edges, so a freshly launched pulse is never raced.
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (ready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      rv = rdata;
      ev = slverr;
      @(posedge clk_sys_in);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      chk(n, rv, e);
   endtask : rdc
   // Waits for a raised request, or a fixed spell when none is expected.
   task automatic wirq(input logic e);
      for (int n = 0; n < 8 && !(e && irq === 1'b1); n++) @(posedge clk_sys_in);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, e});
   endtask : wirq
   task automatic t_regs();
      chk("analog pads", {16'h0, aen}, 32'h0000FFFF);
      rdc(io_port_pkg::OFF_ANALOG_SELECT, 32'h0000FFFF, "analog");
      rdc(io_port_pkg::OFF_DIRECTION_CONTROL, 32'h0000FFFF, "direction");
      apb(1'b1, io_port_pkg::OFF_ANALOG_SELECT, 32'h000000FF);
      chk("analog pads", {16'h0, aen}, 32'h000000FF);
      rdc(io_port_pkg::OFF_PIN_LEVEL_READ, 32'h0000A500, "level");
      apb(1'b1, io_port_pkg::OFF_PULLUP_ENABLE, 32'h000000AA);
      apb(1'b1, io_port_pkg::OFF_PULLDOWN_ENABLE, 32'h00005500);
      chk("pulls", {pu, pd}, 32'h00AA5500);
      apb(1'b0, 12'h030, 32'h0);
      chk("slverr", {31'h0, ev}, 32'h1);
      $display("register test done");
   endtask : t_regs
   task automatic t_pads();
      apb(1'b1, io_port_pkg::OFF_PULLUP_ENABLE, 32'h0);
      apb(1'b1, io_port_pkg::OFF_PULLDOWN_ENABLE, 32'h0);
      apb(1'b1, io_port_pkg::OFF_ANALOG_SELECT, 32'h0);
      apb(1'b1, io_port_pkg::OFF_OUTPUT_LATCH, 32'h00000F0F);
      apb(1'b1, io_port_pkg::OFF_OPEN_DRAIN_SELECT, 32'h00000FF0);
      apb(1'b1, io_port_pkg::OFF_DIRECTION_CONTROL, 32'h0);
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("pad drive", {poe, pout}, 32'hF0FF000F);
      apb(1'b1, io_port_pkg::OFF_ANALOG_SELECT, 32'h00000003);
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk("converter", {16'h0, adrv}, 32'h00000003);
      apb(1'b1, io_port_pkg::OFF_DIRECTION_CONTROL, 32'h0000FFFF);
      apb(1'b1, io_port_pkg::OFF_ANALOG_SELECT, 32'h0);
      $display("pad test done");
   endtask : t_pads
   task automatic t_change();
      sw <= 16'h0000;
      apb(1'b1, io_port_pkg::OFF_CHANGE_ENABLE, 32'h00000010);
      apb(1'b1, io_port_pkg::OFF_IRQ_MASK, 32'h1);
      apb(1'b1, io_port_pkg::OFF_IRQ_STATUS, 32'h1);
      sw <= 16'h0008;
      wirq(1'b0);
      sw <= 16'h0018;
      wirq(1'b1);
      rdc(io_port_pkg::OFF_IRQ_STATUS, 32'h1, "status");
      apb(1'b1, io_port_pkg::OFF_IRQ_STATUS, 32'h1);
      wirq(1'b0);
      @(negedge clk_sys_in);
      run = 1'b0;
      #50 sw = 16'h0008;
      #50 run = 1'b1;
      wirq(1'b1);
      apb(1'b1, io_port_pkg::OFF_IRQ_STATUS, 32'h1);
      apb(1'b1, io_port_pkg::OFF_IRQ_MASK, 32'h0);
      sw <= 16'h0018;
      wirq(1'b0);
      rdc(io_port_pkg::OFF_IRQ_STATUS, 32'h1, "masked status");
      $display("change test done");
   endtask : t_change
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_regs();
      t_pads();
      t_change();
      end_sim();
   end
endmodule : io_port_change_notify_tb
